/* File: hdl/drive_status.sv */
// Drive status and safety monitor outputs with an AXI4-Lite register slave
`include "drive_status_params.svh"

module drive_status #(
    parameter int unsigned INDEX_PERIOD = `INDEX_PERIOD_CYC,
    parameter int unsigned SEEK_LIMIT = `SEEK_LIMIT_CYC,
    parameter int unsigned RECAL_LIMIT = `RECAL_LIMIT_CYC,
    parameter int unsigned UPSPEED_LIMIT = `UPSPEED_LIMIT_CYC,
    parameter int unsigned DIFF_W = 9
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive condition pins (asynchronous)
    input wire logic [31:0] pins_in,
    input wire logic [DIFF_W-1:0] diff_value,
    // Status outputs
    output logic offset_ready,
    output logic file_ready,
    output logic index_pulse,
    output logic sector_clock,
    output logic write_protect,
    output logic port_a_sel,
    output logic port_b_sel,
    output logic plug_enable,
    output logic on_line,
    output logic seq_pick_out,
    output logic positioner_clear_active,
    output logic distance_below_limit,
    output logic distance_zero,
    // Fault outputs
    output logic write_current_fault,
    output logic sink_fault,
    output logic dual_source_fault,
    output logic wrong_current_fault,
    output logic static_write_fault_sum,
    output logic stray_flux_change_fault,
    output logic no_transition_fault,
    output logic dynamic_write_fault_sum,
    output logic write_off_cyl_fault,
    output logic multi_head_fault,
    output logic no_head_fault,
    output logic head_fault_sum,
    output logic phase_lock_lost_fault,
    output logic source_regulator_fault,
    output logic read_write_fault,
    output logic write_offset_fault,
    output logic index_error,
    output logic seek_incomplete,
    output logic general_fault_sum,
    output logic off_cylinder,
    output logic abnormal_stop,
    output logic heads_deselect,
    output logic rw_disable
);

    // ----------------------------------------------------------------
    // Input bit positions within pins_in
    // ----------------------------------------------------------------
    localparam int P_OFF_RESET = 0;
    localparam int P_GO = 1;
    localparam int P_OFFSET_DONE = 2;
    localparam int P_SEEK_DONE = 3;
    localparam int P_RECAL = 4;
    localparam int P_LOADED = 5;
    localparam int P_SERVO = 6;
    localparam int P_WP_SW = 7;
    localparam int P_PORTA_SW = 8;
    localparam int P_PORTB_SW = 9;
    localparam int P_PLUG = 10;
    localparam int P_DC_ON = 11;
    localparam int P_SEQ_IN = 12;
    localparam int P_WCUR = 13;
    localparam int P_WCMD = 14;
    localparam int P_SINK_BAD = 15;
    localparam int P_SRC_EVEN = 16;
    localparam int P_SRC_ODD = 17;
    localparam int P_CUR_WRONG = 18;
    localparam int P_TRANS = 19;
    localparam int P_ON_CYL = 20;
    localparam int P_RCMD = 21;
    localparam int P_REG_BAD = 22;
    localparam int P_PLO_LOST = 23;
    localparam int P_COARSE = 24;
    localparam int P_UNLOAD = 25;
    localparam int P_SEQ_START = 26;
    localparam int P_UPSPEED = 27;
    localparam int P_RETRACT_PWR_LOST = 28;
    localparam int P_LAUNCH = 29;
    localparam int P_RETRACT_FAIL = 30;
    localparam int P_RETRACTING = 31;
    localparam int NFLT = 14;

    typedef struct packed {
        logic [31:0] meta;
        logic [31:0] pin;
        logic [31:0] pin_d;
        drive_status_pkg::pwr_e pwr;
        drive_status_pkg::op_e op;
        logic op_load;
        logic [31:0] op_cnt;
        logic [31:0] up_cnt;
        logic [31:0] rev_cnt;
        logic [6:0] sec_cnt;
        logic [13:0] sec_num;
        logic [31:0] idx_gap;
        logic idx_err;
        logic off_rdy;
        logic f_rdy;
        logic [NFLT-1:0] flt;
        logic seek_inc;
        logic off_cyl;
        logic abn;
        logic recal_was_auto;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic rise(input logic [31:0] now, input logic [31:0] was, input int b);
        rise = now[b] & ~was[b];
    endfunction

    function automatic logic [31:0] read_reg(input state_s s, input logic [7:0] a,
                                             output logic ok);
        ok = 1'b1;
        if (a == `REG_CTRL) begin
            read_reg = s.ctrl;
        end else if (a == `REG_FAULT) begin
            read_reg = {14'h0000, s.abn, s.off_cyl, s.seek_inc, s.idx_err, s.flt};
        end else if (a == `REG_STATUS) begin
            read_reg = {24'h000000, s.f_rdy, s.off_rdy, 4'h0, s.pwr};
        end else if (a == `REG_DIFF) begin
            read_reg = {18'h00000, s.sec_num};
        end else begin
            ok = 1'b0;
            read_reg = 32'h0000_0000;
        end
    endfunction

    logic [NFLT-1:0] cond;
    logic rd_ok;
    logic [31:0] rd_val;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] p;
        logic [31:0] q;
        logic clr;
        logic idx_now;
        p = st_r.pin;
        q = st_r.pin_d;
        idx_now = (st_r.rev_cnt == '0);
        st_nxt = st_r;
        st_nxt.meta = pins_in;
        st_nxt.pin = st_r.meta;
        st_nxt.pin_d = p;
        clr = st_r.ctrl[`CTRL_CLEAR_BIT];
        // Safety detectors
        cond = '0;
        cond[0] = p[P_WCUR] & ~p[P_WCMD];
        cond[1] = p[P_SINK_BAD] & ~p[P_WCMD] & q[P_WCMD];
        cond[2] = p[P_SRC_EVEN] & p[P_SRC_ODD];
        cond[3] = p[P_CUR_WRONG] & p[P_WCMD];
        cond[4] = rise(p, q, P_TRANS) & ~p[P_WCMD];
        cond[5] = 1'b0;
        cond[6] = p[P_WCMD] & ~p[P_ON_CYL];
        cond[7] = 1'b0;
        cond[8] = 1'b0;
        cond[9] = p[P_PLO_LOST];
        cond[10] = p[P_REG_BAD] & p[P_WCMD];
        cond[11] = p[P_RCMD] & p[P_WCMD];
        cond[12] = p[P_WCMD] & st_r.off_rdy;
        cond[13] = 1'b0;
        // Flags stick; a clear from software loses to a new event
        st_nxt.flt = (clr ? '0 : st_r.flt) | cond;
        st_nxt.ctrl[`CTRL_CLEAR_BIT] = 1'b0;
        // Power sequencing
        case (st_r.pwr)
            drive_status_pkg::PWR_OFF: begin
                st_nxt.up_cnt = '0;
                if (p[P_DC_ON] && p[P_SEQ_START] && p[P_SEQ_IN] && !st_r.abn) begin
                    st_nxt.pwr = drive_status_pkg::PWR_SEQ;
                end
            end
            drive_status_pkg::PWR_SEQ: begin
                st_nxt.up_cnt = st_r.up_cnt + 32'h0000_0001;
                if (p[P_LAUNCH]) begin
                    st_nxt.abn = 1'b1;
                end
                if (st_r.up_cnt >= UPSPEED_LIMIT) begin
                    st_nxt.abn = 1'b1;
                end
                if (p[P_UPSPEED]) begin
                    st_nxt.pwr = drive_status_pkg::PWR_UP;
                end
            end
            default: begin
                if (!p[P_DC_ON]) begin
                    st_nxt.pwr = drive_status_pkg::PWR_OFF;
                end
            end
        endcase
        if (p[P_RETRACT_PWR_LOST] || p[P_RETRACT_FAIL]
            || (p[P_RETRACTING] && st_r.op == drive_status_pkg::OP_SEEK)) begin
            st_nxt.abn = 1'b1;
        end
        if (st_nxt.abn || !p[P_DC_ON]) begin
            st_nxt.pwr = st_nxt.abn ? drive_status_pkg::PWR_OFF : st_nxt.pwr;
        end
        // Seek / recalibrate / load timing
        case (st_r.op)
            drive_status_pkg::OP_IDLE: begin
                st_nxt.op_cnt = '0;
                if (rise(p, q, P_GO)) begin
                    st_nxt.op = drive_status_pkg::OP_SEEK;
                    st_nxt.f_rdy = 1'b0;
                end else if (rise(p, q, P_RECAL) || rise(p, q, P_LOADED)
                             && st_r.pwr == drive_status_pkg::PWR_UP) begin
                    st_nxt.op = drive_status_pkg::OP_RECAL;
                    st_nxt.op_load = ~p[P_RECAL];
                    st_nxt.f_rdy = 1'b0;
                end
            end
            drive_status_pkg::OP_SEEK: begin
                st_nxt.op_cnt = st_r.op_cnt + 32'h0000_0001;
                if (rise(p, q, P_SEEK_DONE)) begin
                    st_nxt.op = drive_status_pkg::OP_IDLE;
                    st_nxt.f_rdy = 1'b1;
                end else if (st_r.op_cnt >= SEEK_LIMIT) begin
                    st_nxt.seek_inc = 1'b1;
                    st_nxt.op = drive_status_pkg::OP_IDLE;
                end
            end
            default: begin
                st_nxt.op_cnt = st_r.op_cnt + 32'h0000_0001;
                if (rise(p, q, P_SEEK_DONE)) begin
                    st_nxt.op = drive_status_pkg::OP_IDLE;
                    st_nxt.f_rdy = 1'b1;
                    st_nxt.recal_was_auto = 1'b0;
                end else if (st_r.op_cnt >= RECAL_LIMIT) begin
                    st_nxt.seek_inc = 1'b1;
                    st_nxt.op = drive_status_pkg::OP_IDLE;
                    if (st_r.recal_was_auto) begin
                        st_nxt.abn = 1'b1;
                    end
                end
            end
        endcase
        if (st_r.seek_inc && rise(p, q, P_RECAL)) begin
            st_nxt.recal_was_auto = 1'b1;
        end
        if (!p[P_LOADED]) begin
            st_nxt.f_rdy = 1'b0;
        end
        // Offset ready
        if (rise(p, q, P_OFFSET_DONE)) begin
            st_nxt.off_rdy = 1'b1;
        end
        if (st_r.off_rdy && (rise(p, q, P_OFF_RESET) || rise(p, q, P_GO))) begin
            st_nxt.off_rdy = 1'b0;
        end
        // Off cylinder, latched
        if (!p[P_COARSE] && st_r.f_rdy && !st_r.off_rdy) begin
            st_nxt.off_cyl = 1'b1;
        end
        // Rotation timing
        st_nxt.rev_cnt = (st_r.rev_cnt >= INDEX_PERIOD - 1) ? '0
                         : st_r.rev_cnt + 32'h0000_0001;
        if (idx_now || st_r.sec_cnt == 7'(`SECTOR_PERIOD_CYC - 1)) begin
            st_nxt.sec_cnt = '0;
            st_nxt.sec_num = idx_now ? '0 : st_r.sec_num + 14'h0001;
        end else begin
            st_nxt.sec_cnt = st_r.sec_cnt + 7'h01;
        end
        // Index gap watchdog: a gap beyond the nominal period flags error
        st_nxt.idx_gap = idx_now ? '0 : st_r.idx_gap + 32'h0000_0001;
        if (st_r.idx_gap > INDEX_PERIOD) begin
            st_nxt.idx_err = 1'b1;
        end else if (idx_now) begin
            st_nxt.idx_err = 1'b0;
        end
        // AXI write
        if (s_axi_awvalid && !st_r.aw_got) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_got) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            if (st_r.awaddr == `REG_CTRL) begin
                st_nxt.bresp = 2'h0;
                if (s_axi_wstrb[0]) begin
                    st_nxt.ctrl[7:0] = st_r.wdata[7:0];
                end
            end else begin
                st_nxt.bresp = 2'h2;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // AXI read
        if (s_axi_arvalid && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_val;
            st_nxt.rresp = rd_ok ? 2'h0 : 2'h2;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_comb begin
        rd_val = read_reg(st_r, s_axi_araddr, rd_ok);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic [31:0] pr;
    assign pr = st_r.pin;
    assign s_axi_awready = ~st_r.aw_got;
    assign s_axi_wready = ~st_r.w_got;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = ~st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

    assign offset_ready = st_r.off_rdy;
    assign file_ready = st_r.f_rdy;
    assign index_pulse = st_r.rev_cnt != '0 && st_r.rev_cnt <= `INDEX_WIDTH_CYC;
    assign sector_clock = st_r.sec_cnt < 7'(`SECTOR_WIDTH_CYC);
    assign write_protect = pr[P_WP_SW];
    assign port_a_sel = pr[P_PORTA_SW];
    assign port_b_sel = pr[P_PORTB_SW];
    assign plug_enable = pr[P_PLUG];
    assign on_line = (pr[P_LOADED] & pr[P_SERVO])
                   | (st_r.op == drive_status_pkg::OP_RECAL & pr[P_PLUG]);
    // Pass through unless powering up
    assign seq_pick_out = pr[P_SEQ_IN] & (st_r.pwr != drive_status_pkg::PWR_SEQ);
    assign positioner_clear_active = pr[P_UNLOAD]
        | st_r.op == drive_status_pkg::OP_RECAL;
    assign distance_below_limit = diff_value < DIFF_W'(`DIFF_LIMIT);
    assign distance_zero = diff_value == '0;

    assign write_current_fault = st_r.flt[0];
    assign sink_fault = st_r.flt[1];
    assign dual_source_fault = st_r.flt[2];
    assign wrong_current_fault = st_r.flt[3];
    assign static_write_fault_sum = |st_r.flt[3:0];
    assign stray_flux_change_fault = st_r.flt[4];
    // No transitions: flag is never set, its detector cond[5] is tied to 0
    assign no_transition_fault = st_r.flt[5];
    assign dynamic_write_fault_sum = st_r.flt[4] | st_r.flt[5];
    assign write_off_cyl_fault = st_r.flt[6];
    assign multi_head_fault = st_r.flt[7];
    assign no_head_fault = st_r.flt[8];
    assign head_fault_sum = st_r.flt[7] | st_r.flt[8];
    assign phase_lock_lost_fault = st_r.flt[9];
    assign source_regulator_fault = st_r.flt[10];
    assign read_write_fault = st_r.flt[11];
    assign write_offset_fault = st_r.flt[12];
    assign index_error = st_r.idx_err;
    assign seek_incomplete = st_r.seek_inc;
    assign general_fault_sum = |st_r.flt | st_r.idx_err | st_r.abn;
    assign off_cylinder = st_r.off_cyl;
    assign abnormal_stop = st_r.abn;
    // No-head alone only disables read/write
    assign heads_deselect = |{st_r.flt[12:9], st_r.flt[7:0]};
    assign rw_disable = |st_r.flt;

endmodule

/* File: hdl/drive_status_params.svh */
// Offsets, field positions, reset values and timing counts for the drive status block
`ifndef DRIVE_STATUS_PARAMS_SVH
`define DRIVE_STATUS_PARAMS_SVH

// ----------------------------------------------------------------
// Timing, in ns / us / ms at a 10 ns clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define INDEX_PERIOD_US 16670
`define INDEX_WIDTH_NS 620
`define SECTOR_PERIOD_NS 1240
`define SECTOR_WIDTH_NS 620
`define SECTORS_PER_REV 13440
`define SEEK_LIMIT_MS 100
`define RECAL_LIMIT_MS 750
`define UPSPEED_LIMIT_MS 21700
`define INDEX_PERIOD_CYC (`SECTORS_PER_REV * `SECTOR_PERIOD_CYC)
`define INDEX_WIDTH_CYC ((`INDEX_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECTOR_PERIOD_CYC (`SECTOR_PERIOD_NS / `CLK_PERIOD_NS)
`define SECTOR_WIDTH_CYC ((`SECTOR_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEEK_LIMIT_CYC (`SEEK_LIMIT_MS * 100000)
`define RECAL_LIMIT_CYC (`RECAL_LIMIT_MS * 100000)
`define UPSPEED_LIMIT_CYC (`UPSPEED_LIMIT_MS * 100000)
`define DIFF_LIMIT 32

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_FAULT 8'h04
`define REG_STATUS 8'h08
`define REG_DIFF 8'h0C
`define CTRL_CLEAR_BIT 0
`define CTRL_RST 32'h0000_0000

`endif

/* File: hdl/drive_status_pkg.sv */
// Types shared by the drive status block
package drive_status_pkg;
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_SEQ,
        PWR_UP
    } pwr_e;
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_SEEK,
        OP_RECAL
    } op_e;
endpackage

/* File: verif/ctl_model.sv */
// Controller-side model that drives the drive condition pins
module ctl_model (
    // Clock
    input wire logic aclk,
    // Levels asked for by the bench
    input wire logic [31:0] req_pins,
    // Drive condition pins
    output logic [31:0] pins_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move only just after an edge, like a clocked controller
    always @(posedge aclk) begin
        pins_in <= req_pins;
    end
endmodule

/* File: verif/drive_status_sva.sv */
// Assertions on the drive status outputs
module drive_status_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Inputs watched
    input wire logic [31:0] pins_in,
    input wire logic [8:0] diff_value,
    // Outputs watched
    input wire logic index_pulse,
    input wire logic sector_clock,
    input wire logic write_protect,
    input wire logic write_current_fault,
    input wire logic sink_fault,
    input wire logic dual_source_fault,
    input wire logic wrong_current_fault,
    input wire logic static_write_fault_sum,
    input wire logic stray_flux_change_fault,
    input wire logic no_transition_fault,
    input wire logic dynamic_write_fault_sum,
    input wire logic no_head_fault,
    input wire logic distance_below_limit,
    input wire logic distance_zero,
    input wire logic heads_deselect,
    input wire logic rw_disable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    static_sum_a: assert property (
        (write_current_fault | sink_fault | dual_source_fault | wrong_current_fault)
        |-> ##[0:1] static_write_fault_sum) else $error("static summary missing");
    dynamic_sum_a: assert property (
        (stray_flux_change_fault | no_transition_fault) |-> ##[0:1] dynamic_write_fault_sum)
        else $error("dynamic summary missing");
    write_deselect_a: assert property (
        $rose(write_current_fault) |-> ##[0:1] (heads_deselect && rw_disable))
        else $error("heads not deselected");
    no_head_a: assert property (
        no_head_fault |-> ##[0:1] rw_disable) else $error("read/write not disabled");
    dist_zero_a: assert property (
        distance_zero == (diff_value == 9'h000)) else $error("distance zero wrong");
    dist_below_a: assert property (
        distance_below_limit == (diff_value < 9'h020)) else $error("distance limit wrong");
    index_width_a: assert property (
        $rose(index_pulse) |-> ##61 index_pulse ##1 !index_pulse) else $error("index width");
    sector_shape_a: assert property (
        $rose(sector_clock) |-> ##61 sector_clock ##1 !sector_clock ##61 !sector_clock
        ##1 sector_clock) else $error("sector clock shape");
    protect_follow_a: assert property (
        $stable(pins_in[7]) [*4] |-> write_protect == pins_in[7]) else $error("protect level");
    cover property ($rose(write_current_fault));
    cover property ($rose(index_pulse));
    cover property ($rose(distance_zero));
endmodule

/* File: verif/test_drive_status.sv */
// Self-checking bench for the drive status block
module test_drive_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, pins_in, req_pins;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [8:0] diff_value;
    logic offset_ready, file_ready, index_pulse, sector_clock, write_protect, port_a_sel;
    logic port_b_sel, plug_enable, on_line, seq_pick_out, positioner_clear_active;
    logic distance_below_limit, distance_zero, write_current_fault, sink_fault;
    logic dual_source_fault, wrong_current_fault, static_write_fault_sum;
    logic stray_flux_change_fault, no_transition_fault, dynamic_write_fault_sum;
    logic write_off_cyl_fault, multi_head_fault, no_head_fault, head_fault_sum;
    logic phase_lock_lost_fault, source_regulator_fault, read_write_fault, write_offset_fault;
    logic index_error, seek_incomplete, general_fault_sum, off_cylinder, abnormal_stop;
    logic heads_deselect, rw_disable;
    int errors, n_checks;
    wire logic [7:0] flg = {phase_lock_lost_fault, source_regulator_fault, read_write_fault,
        write_off_cyl_fault, stray_flux_change_fault, wrong_current_fault, dual_source_fault,
        write_current_fault};
    // Short index period keeps the run brief
    drive_status #(.INDEX_PERIOD(248), .SEEK_LIMIT(500), .RECAL_LIMIT(800),
        .UPSPEED_LIMIT(1000)) drive_status_i (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pins_in, .diff_value, .offset_ready, .file_ready, .index_pulse,
        .sector_clock, .write_protect, .port_a_sel, .port_b_sel, .plug_enable, .on_line,
        .seq_pick_out, .positioner_clear_active, .distance_below_limit, .distance_zero,
        .write_current_fault, .sink_fault, .dual_source_fault, .wrong_current_fault,
        .static_write_fault_sum, .stray_flux_change_fault, .no_transition_fault,
        .dynamic_write_fault_sum, .write_off_cyl_fault, .multi_head_fault, .no_head_fault,
        .head_fault_sum, .phase_lock_lost_fault, .source_regulator_fault, .read_write_fault,
        .write_offset_fault, .index_error, .seek_incomplete, .general_fault_sum,
        .off_cylinder, .abnormal_stop, .heads_deselect, .rw_disable);
    ctl_model ctl_model_i (.aclk, .req_pins, .pins_in);

    task automatic give_verdict();
        if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ----------------------------------------
    // Bus cycles, always entered just after an edge
    // ----------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit b;
        b = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                b = 1;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit b;
        b = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                b = 1;
            end
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_axi();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(8'h40, d, r);
        chk("unmapped rresp", 32'h2, r);
        chk("unmapped rdata", 32'h0, d);
        axi_wr(8'h40, 32'h1, r);
        chk("unmapped bresp", 32'h2, r);
    endtask
    task automatic t_panel();
        for (int i = 0; i < 4; i++) begin
            req_pins <= 32'h80 << i;
            tick(6);
            chk("panel", 32'h1 << i,
                {plug_enable, port_b_sel, port_a_sel, write_protect});
        end
        req_pins <= 32'h0200_1060;
        tick(6);
        chk("online", 32'h1, on_line);
        chk("pick out", 32'h1, seq_pick_out);
        chk("clear", 32'h1, positioner_clear_active);
        req_pins <= '0;
        tick(6);
        chk("offline", 32'h0, on_line);
    endtask
    task automatic t_dist();
        logic [8:0] v[5] = '{9'h000, 9'h001, 9'h01F, 9'h020, 9'h1FF};
        foreach (v[i]) begin
            diff_value <= v[i];
            tick(2);
            chk("dist", {v[i] < 9'h020, v[i] == 9'h000},
                {distance_below_limit, distance_zero});
        end
    endtask
    task automatic t_pulse(input bit idx, input int w, input int p);
        int hi, lo;
        hi = 0;
        lo = 0;
        while ((idx ? index_pulse : sector_clock) !== 1'b0) tick(1);
        while ((idx ? index_pulse : sector_clock) !== 1'b1) tick(1);
        while ((idx ? index_pulse : sector_clock) === 1'b1) begin
            hi++;
            tick(1);
        end
        while ((idx ? index_pulse : sector_clock) === 1'b0) begin
            lo++;
            tick(1);
        end
        chk(idx ? "index width" : "sector width", w, hi);
        chk(idx ? "index period" : "sector period", p, hi + lo);
    endtask
    task automatic t_faults();
        logic [31:0] m[8] = '{32'h0000_2000, 32'h0003_0000, 32'h001C_6000, 32'h0008_0000,
            32'h0008_6000, 32'h0038_6000, 32'h0058_6000, 32'h0098_6000};
        logic [1:0] r;
        for (int i = 0; i < 8; i++) begin
            req_pins <= m[i];
            tick(8);
            chk("fault flag", 32'h1, flg[i]);
            chk("deselect", 32'h3, {heads_deselect, rw_disable});
            if (i < 3) chk("static sum", 32'h1, static_write_fault_sum);
            if (i == 3) chk("dynamic sum", 32'h1, dynamic_write_fault_sum);
            req_pins <= '0;
            tick(8);
            chk("fault held", 32'h1, flg[i]);
            chk("general sum", 32'h1, general_fault_sum);
            axi_wr(8'h00, 32'h1, r);
            chk("clear bresp", 32'h0, r);
            tick(4);
            chk("fault cleared", 32'h0, flg);
        end
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_pins, diff_value} = '0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hF;
        errors = 0;
        n_checks = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        tick(2);
        chk("abnormal stop", 32'h0, abnormal_stop);
        t_axi();
        t_panel();
        t_dist();
        t_pulse(1'b0, 62, 124);
        t_pulse(1'b1, 62, 248);
        t_faults();
        give_verdict();
    end
    // Whole run needs well under 10k cycles
    initial begin
        #200us;
        errors++;
        give_verdict();
    end
endmodule

bind drive_status drive_status_sva drive_status_sva_i (.aclk, .aresetn, .pins_in,
    .diff_value, .index_pulse, .sector_clock, .write_protect, .write_current_fault,
    .sink_fault, .dual_source_fault, .wrong_current_fault, .static_write_fault_sum,
    .stray_flux_change_fault, .no_transition_fault, .dynamic_write_fault_sum,
    .no_head_fault, .distance_below_limit, .distance_zero, .heads_deselect, .rw_disable);
